/* inc/pcc_pkg.sv */
// pcc_pkg: register indices, field positions, reset values and the channel
// configuration carrier for the six-channel pwm block.
// assumes: register index n sits at apb byte address 4*n, data in the low byte.

package pcc_pkg;

   // channel count and widths
   localparam int          NUM_CH        = 6;
   localparam int          CNT_W         = 8;
   localparam int          PRE_W         = 3;
   localparam int          PDIV_W        = 7;

   ////////////////////////////////////////////////////////////////////////////
   // register indices (byte address is four times the index)
   localparam logic [7:0]  IDX_ENABLE    = 8'h00;
   localparam logic [7:0]  IDX_POLARITY  = 8'h01;
   localparam logic [7:0]  IDX_CLK_SEL   = 8'h02;
   localparam logic [7:0]  IDX_PRESCALE  = 8'h03;
   localparam logic [7:0]  IDX_CENTER    = 8'h04;
   localparam logic [7:0]  IDX_SCALE_A   = 8'h08;
   localparam logic [7:0]  IDX_SCALE_B   = 8'h09;
   localparam logic [7:0]  IDX_COUNT0    = 8'h0c;
   localparam logic [7:0]  IDX_PERIOD0   = 8'h12;
   localparam logic [7:0]  IDX_DUTY0     = 8'h18;

   ////////////////////////////////////////////////////////////////////////////
   // field positions inside the prescale register
   localparam int          PRE_A_LSB     = 0;
   localparam int          PRE_B_LSB     = 4;

   // channels clocked from the b pair; all others use the a pair
   localparam logic [5:0]  B_GROUP_MASK  = 6'h0c;

   ////////////////////////////////////////////////////////////////////////////
   // values after reset
   localparam logic [5:0]  RST_CTRL      = 6'h00;
   localparam logic [2:0]  RST_PRE       = 3'h0;
   localparam logic [7:0]  RST_SCALE     = 8'h00;
   localparam logic [7:0]  RST_PERIOD    = 8'hff;
   localparam logic [7:0]  RST_DUTY      = 8'h00;
   localparam logic [6:0]  RST_PDIV      = 7'h00;

   ////////////////////////////////////////////////////////////////////////////
   // per-channel configuration handed to each channel engine
   typedef struct packed {
      logic             enable;
      logic             polarity;
      logic             center;
      logic [7:0]       period;
      logic [7:0]       duty;
   } pcc_cfg_t;

endpackage

/* logic/pcc_channel.sv */
// pcc_channel: one 8-bit pwm channel engine, left or center aligned.
// assumes: tick is a one-cycle enable from the selected clock source, same clock.

`timescale 1ns/1ps
`default_nettype none

module pcc_channel (
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   input  wire logic              tick,
   input  wire pcc_pkg::pcc_cfg_t cfg,
   output logic                   pwm_out,
   output logic [7:0]             count
);
   import pcc_pkg::*;

   logic             running_reg;
   logic             dir_up_reg;
   logic [7:0]       count_reg;
   logic             pwm_out_reg;
   logic             phase;
   logic             active;
   logic [8:0]       count_inc;

   assign active    = running_reg & cfg.enable;
   assign count_inc = {1'b0, count_reg} + 9'h001;

   ////////////////////////////////////////////////////////////////////////////
   // start only on the first tick after enable, so the first cycle is whole
   always_ff @(posedge sys_clk) begin
      if (!reset_n || !cfg.enable) begin
         running_reg <= 1'b0;
      end else if (tick) begin
         running_reg <= 1'b1;                      // [R16]
      end
   end

   // counter advances on the selected tick only
   always_ff @(posedge sys_clk) begin
      if (!reset_n || !active) begin
         count_reg  <= 8'h00;
         dir_up_reg <= 1'b1;
      end else if (tick) begin
         if (cfg.period == 8'h00) begin
            count_reg <= 8'h00;                    // zero period holds the counter at zero
         end else if (!cfg.center) begin
            // left aligned: 0 .. period-1, then wrap
            if (count_inc >= {1'b0, cfg.period}) begin
               count_reg <= 8'h00;                 // [R12]
            end else begin
               count_reg <= count_inc[7:0];
            end
         end else if (dir_up_reg) begin
            // center aligned: up to period, then back down to zero
            if (count_inc >= {1'b0, cfg.period}) begin
               count_reg  <= cfg.period;           // [R11]
               dir_up_reg <= 1'b0;
            end else begin
               count_reg <= count_inc[7:0];
            end
         end else begin
            if (count_reg <= 8'h01) begin
               count_reg  <= 8'h00;                // [R11]
               dir_up_reg <= 1'b1;
            end else begin
               count_reg <= count_reg - 8'h01;
            end
         end
      end
   end

   // duty compare: the output leaves its starting level once the duty count is met
   assign phase = (count_reg < cfg.duty);          // [R17]

   // polarity is applied every clock, not per cycle, so a change acts at once
   always_ff @(posedge sys_clk) begin
      if (!reset_n || !active) begin
         pwm_out_reg <= 1'b0;
      end else if (cfg.polarity) begin
         pwm_out_reg <= phase;                     // [R1] [R3]
      end else begin
         pwm_out_reg <= ~phase;                    // [R2] [R3]
      end
   end

   assign pwm_out = pwm_out_reg;
   assign count   = count_reg;

   ////////////////////////////////////////////////////////////////////////////
   idle_output_a: assert property (@(posedge sys_clk) disable iff (!reset_n)   // [R16]
      !running_reg |=> !pwm_out_reg) else $error("output not idle before first tick");

   pol_high_a: assert property (@(posedge sys_clk) disable iff (!reset_n)      // [R1]
      (active && phase && cfg.polarity) |=> pwm_out_reg) else $error("high polarity start level wrong");

   pol_low_a: assert property (@(posedge sys_clk) disable iff (!reset_n)       // [R2]
      (active && phase && !cfg.polarity) |=> !pwm_out_reg) else $error("low polarity start level wrong");

   left_wrap_a: assert property (@(posedge sys_clk) disable iff (!reset_n)     // [R12]
      (active && tick && !cfg.center && cfg.period != 8'h00 && count_inc >= {1'b0, cfg.period})
      |=> count_reg == 8'h00) else $error("left aligned counter did not wrap");

   center_turn_a: assert property (@(posedge sys_clk) disable iff (!reset_n)   // [R11]
      (active && tick && cfg.center && dir_up_reg && cfg.period != 8'h00 && count_inc >= {1'b0, cfg.period})
      |=> (count_reg == $past(cfg.period)) && !dir_up_reg) else $error("center counter did not turn");

endmodule

`default_nettype wire

/* logic/pcc_top.sv */
// pcc_top: six-channel pwm with polarity, alignment, clock select and the
// clock a/b prescalers and scalers, reached over an apb slave.
// assumes: apb master on sys_clk; pwm outputs go straight to pins.
//
// Notes on behaviour
// R1: polarity bit 1: output starts high each cycle, goes low at duty count.
// R2: polarity bit 0: output starts low each cycle, goes high at duty count.
// R3: polarity writes act at once, may give one short or long pulse.
// R4: polarity and center-align registers hold bit n for channel n, 0 to 5.
// R5: channels 0,1,4,5 run from clock a when select is 0, scaled a when 1.
// R6: channels 2,3 run from clock b when select is 0, scaled b when 1.
// R7: clock-select writes act at once, may distort one pulse.
// R8: low three-bit field sets clock a to bus clock over two to the code.
// R9: upper three-bit field sets clock b to bus clock over two to the code.
// R10: prescale writes act at once, may distort one pulse.
// R11: center-align bit 1 gives center-aligned output.
// R12: center-align bit 0 gives left-aligned output.
// R13: software changes center-align only while the channel is disabled.
// R14: these four registers read and write at any time, in any mode.
// R15: scaled clock is its base clock over twice the scale value.
// R16: after enable, waveform appears at the selected clock's next cycle.
// R17: each tick compares counter with duty; output leaves start level on match.

`timescale 1ns/1ps
`default_nettype none

module pcc_top #(
   parameter int ADDR_W = 10
) (
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic [5:0]             pwm_out
);
   import pcc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // software-visible state
   logic [5:0]       enable_reg;
   logic [5:0]       polarity_reg;
   logic [5:0]       clk_sel_reg;
   logic [5:0]       center_reg;
   logic [2:0]       pre_a_reg;
   logic [2:0]       pre_b_reg;
   logic [7:0]       scale_reg [2];
   logic [7:0]       period_reg [NUM_CH];
   logic [7:0]       duty_reg [NUM_CH];

   // bus slave state
   logic             pready_reg;
   logic             pslverr_reg;
   logic [31:0]      prdata_reg;

   // clock generation
   logic [6:0]       pdiv_reg;
   logic [7:0]       scl_cnt_reg [2];
   logic             scl_phase_reg [2];
   logic             base_tick [2];
   logic             scaled_tick [2];
   logic [2:0]       pre_code [2];
   logic [5:0]       ch_tick;
   logic [7:0]       ch_count [NUM_CH];

   // decode helpers
   logic [7:0]       reg_idx;
   logic             setup_ph;
   logic             done_ph;
   logic             wr_en;
   logic [7:0]       wbyte;
   logic [31:0]      rd_data;
   logic             rd_hit;

   assign reg_idx  = paddr[9:2];
   assign setup_ph = psel & penable & ~pready_reg;
   assign done_ph  = psel & penable & pready_reg;
   assign wr_en    = done_ph & pwrite & pstrb[0] & ~pslverr_reg;
   assign wbyte    = pwdata[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // apb handshake: one wait state, answer registered so outputs come from flops
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= setup_ph;
      end
   end

   // read data and error captured in the wait state, held while pready is high
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (setup_ph) begin
         prdata_reg  <= pwrite ? 32'h0000_0000 : rd_data;
         pslverr_reg <= ~rd_hit;
      end else if (!psel) begin
         pslverr_reg <= 1'b0;
      end
   end

   // read mux: narrow registers in the low bits, upper bits zero
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (reg_idx)
         IDX_ENABLE:   rd_data[5:0] = enable_reg;
         IDX_POLARITY: rd_data[5:0] = polarity_reg;     // [R14]
         IDX_CLK_SEL:  rd_data[5:0] = clk_sel_reg;      // [R14]
         IDX_CENTER:   rd_data[5:0] = center_reg;       // [R14]
         IDX_PRESCALE: begin
            rd_data[PRE_A_LSB +: PRE_W] = pre_a_reg;    // [R14]
            rd_data[PRE_B_LSB +: PRE_W] = pre_b_reg;
         end
         IDX_SCALE_A:  rd_data[7:0] = scale_reg[0];
         IDX_SCALE_B:  rd_data[7:0] = scale_reg[1];
         default: begin
            rd_hit = 1'b0;
            for (int i = 0; i < NUM_CH; i++) begin
               if (reg_idx == IDX_COUNT0 + 8'(i)) begin
                  rd_data[7:0] = ch_count[i];           // live counter state
                  rd_hit       = 1'b1;
               end
               if (reg_idx == IDX_PERIOD0 + 8'(i)) begin
                  rd_data[7:0] = period_reg[i];
                  rd_hit       = 1'b1;
               end
               if (reg_idx == IDX_DUTY0 + 8'(i)) begin
                  rd_data[7:0] = duty_reg[i];
                  rd_hit       = 1'b1;
               end
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode and select registers; no cycle-boundary shadowing, writes act at once
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         enable_reg   <= RST_CTRL;
         polarity_reg <= RST_CTRL;
         clk_sel_reg  <= RST_CTRL;
         center_reg   <= RST_CTRL;
      end else if (wr_en) begin
         case (reg_idx)
            IDX_ENABLE:   enable_reg   <= wbyte[5:0];
            IDX_POLARITY: polarity_reg <= wbyte[5:0];   // [R3] [R4]
            IDX_CLK_SEL:  clk_sel_reg  <= wbyte[5:0];   // [R7]
            IDX_CENTER:   center_reg   <= wbyte[5:0];   // [R4] [R13]
            default: ;
         endcase
      end
   end

   // prescale and scale registers, also live immediately
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         pre_a_reg    <= RST_PRE;
         pre_b_reg    <= RST_PRE;
         scale_reg[0] <= RST_SCALE;
         scale_reg[1] <= RST_SCALE;
      end else if (wr_en) begin
         case (reg_idx)
            IDX_PRESCALE: begin
               pre_a_reg <= wbyte[PRE_A_LSB +: PRE_W];  // [R8] [R10]
               pre_b_reg <= wbyte[PRE_B_LSB +: PRE_W];  // [R9] [R10]
            end
            IDX_SCALE_A:  scale_reg[0] <= wbyte;
            IDX_SCALE_B:  scale_reg[1] <= wbyte;
            default: ;
         endcase
      end
   end

   // per-channel period and duty
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         for (int i = 0; i < NUM_CH; i++) begin
            period_reg[i] <= RST_PERIOD;
            duty_reg[i]   <= RST_DUTY;
         end
      end else if (wr_en) begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (reg_idx == IDX_PERIOD0 + 8'(i)) begin
               period_reg[i] <= wbyte;
            end
            if (reg_idx == IDX_DUTY0 + 8'(i)) begin
               duty_reg[i] <= wbyte;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared prescale divider; stops when no channel is enabled to save power
   always_ff @(posedge sys_clk) begin
      if (!reset_n || enable_reg == 6'h00) begin
         pdiv_reg <= RST_PDIV;
      end else begin
         pdiv_reg <= pdiv_reg + 7'h01;
      end
   end

   assign pre_code[0] = pre_a_reg;
   assign pre_code[1] = pre_b_reg;

   // index 0 is the a pair, index 1 the b pair
   for (genvar g = 0; g < 2; g++) begin : g_clk
      logic [6:0] mask;
      logic       scl_hit;

      // a tick every 2**code bus clocks: low code bits of the divider all ones
      assign mask          = 7'(7'h7f >> (3'h7 - pre_code[g]));
      assign base_tick[g]  = ((pdiv_reg & mask) == mask) && (enable_reg != 6'h00); // [R8] [R9]

      // scale 0 wraps to 256; a count left above a newly shrunk scale hits at once
      // instead of running the whole 8-bit circle before the first scaled tick
      assign scl_hit       = (scl_cnt_reg[g] >= scale_reg[g] - 8'h01);
      assign scaled_tick[g] = base_tick[g] & scl_hit & scl_phase_reg[g];       // [R15]

      // scaled clock: toggle a phase every scale base ticks, tick on every second
      always_ff @(posedge sys_clk) begin
         if (!reset_n) begin
            scl_cnt_reg[g]   <= 8'h00;
            scl_phase_reg[g] <= 1'b0;
         end else if (base_tick[g]) begin
            if (scl_hit) begin
               scl_cnt_reg[g]   <= 8'h00;                                      // [R15]
               scl_phase_reg[g] <= ~scl_phase_reg[g];
            end else begin
               scl_cnt_reg[g] <= scl_cnt_reg[g] + 8'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // channel engines; the select is combinational so a change acts on the next tick
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      localparam int GRP = B_GROUP_MASK[i] ? 1 : 0;
      pcc_cfg_t cfg;

      assign ch_tick[i] = clk_sel_reg[i] ? scaled_tick[GRP] : base_tick[GRP]; // [R5] [R6] [R7]

      assign cfg.enable   = enable_reg[i];
      assign cfg.polarity = polarity_reg[i];
      assign cfg.center   = center_reg[i];                                    // [R11] [R12]
      assign cfg.period   = period_reg[i];
      assign cfg.duty     = duty_reg[i];

      pcc_channel u_ch (
         .sys_clk (sys_clk),
         .reset_n (reset_n),
         .tick    (ch_tick[i]),
         .cfg     (cfg),
         .pwm_out (pwm_out[i]),
         .count   (ch_count[i])
      );
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;

   ////////////////////////////////////////////////////////////////////////////
   prescale_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)  // [R8]
      (pre_a_reg == 3'h0 && enable_reg != 6'h00) |-> base_tick[0]) else $error("undivided clock a missed a tick");

   prescale_half_a: assert property (@(posedge sys_clk) disable iff (!reset_n)  // [R9]
      (base_tick[1] && pre_b_reg == 3'h1) |=> (!base_tick[1] || pre_b_reg != 3'h1))
      else $error("clock b over two ticked twice in a row");

   scaled_sub_a: assert property (@(posedge sys_clk) disable iff (!reset_n)     // [R15]
      scaled_tick[0] |-> base_tick[0] && scl_phase_reg[0]) else $error("scaled a tick off its base tick");

   select_route_a: assert property (@(posedge sys_clk) disable iff (!reset_n)   // [R6]
      (clk_sel_reg[2] && !scaled_tick[1]) |-> !ch_tick[2]) else $error("channel 2 ticked off scaled b");

   pol_write_a: assert property (@(posedge sys_clk) disable iff (!reset_n)      // [R14]
      (wr_en && reg_idx == IDX_POLARITY) |=> polarity_reg == $past(pwdata[5:0]))
      else $error("polarity write not stored");

   pre_write_a: assert property (@(posedge sys_clk) disable iff (!reset_n)      // [R10]
      (wr_en && reg_idx == IDX_PRESCALE) |=> (pre_a_reg == $past(wbyte[PRE_A_LSB +: PRE_W])
      && pre_b_reg == $past(wbyte[PRE_B_LSB +: PRE_W]))) else $error("prescale write not live at once");

   sel_write_a: assert property (@(posedge sys_clk) disable iff (!reset_n)      // [R7]
      (wr_en && reg_idx == IDX_CLK_SEL) |=> clk_sel_reg == $past(wbyte[5:0]))
      else $error("clock select write not stored");

   ready_pulse_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      setup_ph |=> pready_reg ##1 !pready_reg) else $error("pready not a single cycle answer");

endmodule

`default_nettype wire

/* verif/pcc_top_tb.sv */
// pcc_top_tb: self-checking bench for the six-channel pwm configuration block.
// assumes: pcc_pkg compiled first; this bench is the only apb master.

`timescale 1ns/1ps
`default_nettype none

module pcc_top_tb;
   import pcc_pkg::*;

   logic        sys_clk;
   logic        reset_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [9:0]  paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [5:0]  pwm_out;
   int          fails;
   int          cmp_count;
   int          seed;
   int          mdl [0:31];
   logic [31:0] rd;
   logic        er;
   int          per, dty, sca, c, tk, t, ones, rises;
   // one column per waveform case; one row each for channel, polarity, center, select, prescale a/b
   int          cf_ch  [7] = '{0, 1, 2, 3, 4, 5, 4};
   int          cf_pol [7] = '{1, 0, 1, 1, 1, 0, 1};
   int          cf_cae [7] = '{0, 0, 0, 0, 1, 0, 0};
   int          cf_sel [7] = '{0, 0, 0, 1, 0, 1, 0};
   int          cf_pa  [7] = '{0, 2, 3, 0, 1, 1, 7};
   int          cf_pb  [7] = '{5, 5, 1, 0, 5, 5, 5};

   pcc_top #(.ADDR_W(10)) dut (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .pstrb   (pstrb),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .pwm_out (pwm_out)
   );

   ////////////////////////////////////////////////////////////
   // free-running bus clock, 10 ns
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // compare helpers, one per kind of result
   task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk_cnt(input string nm, input int exp, input int got);
      cmp_count++;
      if (got != exp) begin
         fails++;
         $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr_en, input logic [7:0] idx, input logic [31:0] wd,
                      input logic [3:0] st, output logic [31:0] rdv, output logic err);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr_en;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      pstrb   <= st;
      @(posedge sys_clk);
      penable <= 1'b1;
      // no cycle count assumed here: a missing answer is caught by the watchdog
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // write through the bus and mirror the stored bits in the model
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d, 4'hf, rd, er);
      mdl[idx] = (idx == IDX_PRESCALE) ? (d & 32'h77) : (idx <= IDX_CENTER) ? (d & 32'h3f) : (d & 32'hff);
   endtask

   task automatic rd_chk(input logic [7:0] idx);
      apb(1'b0, idx, 32'h0, 4'h0, rd, er);
      chk_reg("prdata", mdl[idx], rd);
      chk_reg("pslverr", 32'h0, {31'h0, er});
   endtask

   // counts high cycles and rising edges; window spans whole periods so phase drops out
   task automatic meas(input int ch, input int len, output int o, output int r);
      logic prev;
      o = 0;
      r = 0;
      @(posedge sys_clk);
      prev = pwm_out[ch];
      repeat (len) begin
         @(posedge sys_clk);
         if (pwm_out[ch] === 1'b1) o++;
         if (pwm_out[ch] === 1'b1 && prev === 1'b0) r++;
         prev = pwm_out[ch];
      end
      chk_reg("idle_outputs", 32'h0, {26'h0, pwm_out & ~(6'h01 << ch)});
   endtask

   task automatic tally_and_finish;
      if (fails == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   // watchdog: the whole sequence needs well under 20k cycles
   initial begin
      repeat (60000) @(posedge sys_clk);
      fails++;
      tally_and_finish();
   end

   ////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      seed = 5;
      fails = 0;
      cmp_count = 0;
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 10'h0;
      pwdata = 32'h0;
      pstrb = 4'h0;
      foreach (mdl[k]) mdl[k] = (k >= 18 && k <= 23) ? 255 : 0;
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      chk_reg("pwm_out_reset", 32'h0, {26'h0, pwm_out});
      for (int i = 0; i <= 4; i++) rd_chk(8'(i));
      // random read-back of the four configuration registers
      for (int i = 0; i < 10; i++) begin
         c = 1 + ($unsigned($random(seed)) % 4);
         wr(8'(c), $random(seed));
         rd_chk(8'(c));
      end
      apb(1'b1, IDX_POLARITY, 32'hff, 4'h0, rd, er);
      rd_chk(IDX_POLARITY);
      apb(1'b0, 8'h05, 32'h0, 4'h0, rd, er);
      chk_reg("unmapped_err", 32'h1, {31'h0, er});
      chk_reg("unmapped_data", 32'h0, rd);
      // waveform cases: period and high time in ticks of the selected clock
      for (int i = 0; i < 7; i++) begin
         per = 2 + ($unsigned($random(seed)) % 5);
         dty = 1 + ($unsigned($random(seed)) % (per - 1));
         sca = 1 + ($unsigned($random(seed)) % 3);
         c = cf_ch[i];
         wr(IDX_PRESCALE, (cf_pb[i] << PRE_B_LSB) | (cf_pa[i] << PRE_A_LSB));
         wr(IDX_POLARITY, cf_pol[i] << c);
         wr(IDX_CLK_SEL, cf_sel[i] << c);
         wr(IDX_CENTER, cf_cae[i] << c);
         wr(IDX_SCALE_A, sca);
         wr(IDX_SCALE_B, sca);
         wr(8'(IDX_PERIOD0 + c), per);
         wr(8'(IDX_DUTY0 + c), dty);
         wr(IDX_ENABLE, 1 << c);
         tk = (1 << (B_GROUP_MASK[c] ? cf_pb[i] : cf_pa[i])) * (cf_sel[i] ? 2 * sca : 1);
         t = per * tk * (cf_cae[i] ? 2 : 1);
         repeat (2 * t + 4) @(posedge sys_clk);
         meas(c, 2 * t, ones, rises);
         chk_cnt("rises", 2, rises);
         if (cf_cae[i] == 0) chk_cnt("ones", 2 * tk * (cf_pol[i] ? dty : per - dty), ones);
         wr(IDX_ENABLE, 0);
      end
      // polarity flip on a slow channel must act long before the cycle ends
      wr(IDX_PRESCALE, 32'h77);
      wr(IDX_CLK_SEL, 0);
      wr(IDX_CENTER, 0);
      wr(IDX_PERIOD0, 32'hff);
      // duty above every count keeps the start level, so a running channel differs from idle
      wr(IDX_DUTY0, 32'hff);
      wr(IDX_POLARITY, 1);
      wr(IDX_ENABLE, 1);
      repeat (300) @(posedge sys_clk);
      chk_reg("pwm_pol1", 32'h1, {31'h0, pwm_out[0]});
      wr(IDX_POLARITY, 0);
      repeat (3) @(posedge sys_clk);
      chk_reg("pwm_pol0", 32'h0, {31'h0, pwm_out[0]});
      wr(IDX_PRESCALE, 32'h13);
      rd_chk(IDX_PRESCALE);
      rd_chk(IDX_POLARITY);
      tally_and_finish();
   end

endmodule

`default_nettype wire
